// >>> bdmm_core_model.sv
// bdmm_core_model: core side stand-in holding pc low and one peripheral sfr
// assumes the decoder's combinational strobes, one access per cycle
`timescale 1ns/1ns
`default_nettype none
module bdmm_core_model
    import bdmm_pkg::*;
(
    // clock
    input wire logic i_clk,
    // decoder side
    input wire logic i_pcl_wr,
    input wire logic [7:0] i_wdata,
    input wire bdmm_periph_req_t i_preq,
    // answers
    output logic [7:0] o_pc_low,
    output logic [7:0] o_prdata,
    output logic o_phit
);
    logic [7:0] port_ff;
    // one peripheral at 05h of bank 0 only
    assign o_phit = (i_preq.addr == 8'h05);
    // no hit: inverse, so a stale value cannot pass
    assign o_prdata = o_phit ? port_ff : ~port_ff;
    always_ff @(posedge i_clk) begin
        if (i_pcl_wr) begin
            o_pc_low <= i_wdata;
        end
        if (i_preq.wr && o_phit) begin
            port_ff <= i_preq.wdata;
        end
    end
endmodule // bdmm_core_model
`default_nettype wire

// >>> bdmm_memory_map.sv
// bdmm_memory_map: banked data memory decode, core sfr storage, gpr ram,
// calibration constant store and fetch guard.
// assumes the core presents one access per cycle; peripheral sfrs live elsewhere.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - bank-select clear sends direct accesses to the first bank
// - bank-select set sends direct accesses to the second bank at 80h
// - each bank is 128 bytes, offsets 00h to 7Fh
// - lowest 32 offsets of each bank decode as special function registers
// - gpr ram at 20h-7Fh and A0h-FFh, 96 bytes per bank
// - pc low, flags, pointer, pc latch, interrupt control mirrored in both banks
// - unimplemented locations read as zero
// - offset 00h/80h has no storage, only indirect access
// - both direct and indirect addressing are accepted
// - sfrs are static flip-flops, contents kept while the clock stops
// - calibration region from 0FC0h holds constants, never fetched as code
// - each constant is four words: exponent, mantissa high, middle, low
// - indirect location uses the pointer register as data address
module bdmm_memory_map
    import bdmm_pkg::*;
#(
    parameter int unsigned GPR_DEPTH = GPR_PER_BANK,
    parameter int unsigned CAL_DEPTH = CAL_WORDS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // core data access
    input wire bdmm_core_req_t i_core_req,
    output logic [7:0] o_rdata,
    output logic [7:0] o_eff_addr,
    output logic o_hit_unimpl,
    output bdmm_core_regs_t o_core_regs,
    // program counter low byte lives in the core
    input wire logic [7:0] i_pc_low,
    output logic o_pcl_wr,
    // peripheral sfrs outside this block
    output bdmm_periph_req_t o_periph_req,
    input wire logic [7:0] i_periph_rdata,
    input wire logic i_periph_hit,
    // program fetch guard
    input wire logic [11:0] i_fetch_addr,
    input wire logic i_fetch_valid,
    output logic o_fetch_fault,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    localparam int unsigned CAL_IDX_W = $clog2(CAL_DEPTH);
    localparam int unsigned GPR_IDX_W = $clog2(GPR_DEPTH);

    function automatic bdmm_hit_t classify(input logic [6:0] ofs);
        if (ofs >= OFS_GPR_FIRST) begin
            return BDMM_HIT_GPR;
        end
        return BDMM_HIT_SFR;
    endfunction

    logic [7:0] flags_ff;
    logic [7:0] pointer_ff;
    logic [7:0] pclatch_ff;
    logic [7:0] intctl_ff;
    logic [7:0] gpr_ff [2][GPR_DEPTH];
    logic [7:0] cal_ff [CAL_DEPTH];
    logic [7:0] rdata_ff;
    logic fetch_fault_ff;
    logic cal_lock_ff;
    logic [CAL_IDX_W-1:0] cal_idx_ff;
    logic ack_ff;
    logic [31:0] avs_rdata_mux;

    logic bank_sel;
    logic [7:0] eff_addr;
    logic [6:0] ofs;
    logic bank;
    bdmm_hit_t hit;
    logic [GPR_IDX_W-1:0] gpr_idx;
    logic core_wr;
    logic sfr_core;
    logic sfr_is_ind;
    logic [7:0] nxt_rdata;
    logic unimpl;

    assign bank_sel = flags_ff[FLAGS_BANK_BIT];

    // indirect through the pointer, else bank bit over instruction bits
    always_comb begin
        if (i_core_req.indirect || i_core_req.dir_ofs == OFS_INDIRECT) begin
            eff_addr = pointer_ff;
        end else begin
            eff_addr = {bank_sel, i_core_req.dir_ofs};
        end
    end

    assign ofs = eff_addr[BANK_ADDR_W-1:0];
    assign bank = eff_addr[DADDR_W-1];
    assign hit = classify(ofs);
    assign gpr_idx = GPR_IDX_W'(ofs - OFS_GPR_FIRST);
    assign core_wr = i_core_req.wr;
    // a pointer that itself names the indirect slot resolves to no storage
    assign sfr_is_ind = (ofs == OFS_INDIRECT);
    assign sfr_core = (ofs == OFS_PCL) || (ofs == OFS_FLAGS) || (ofs == OFS_POINTER)
        || (ofs == OFS_PCLATCH) || (ofs == OFS_INTCTL);

    // read mux; bank bit ignored for the mirrored core registers
    always_comb begin
        nxt_rdata = ZERO_BYTE;
        unimpl = 1'b0;
        unique case (hit)
            BDMM_HIT_GPR: nxt_rdata = gpr_ff[bank][gpr_idx];
            BDMM_HIT_SFR: begin
                if (sfr_is_ind) begin
                    unimpl = 1'b1;
                end else if (ofs == OFS_PCL) begin
                    nxt_rdata = i_pc_low;
                end else if (ofs == OFS_FLAGS) begin
                    nxt_rdata = flags_ff;
                end else if (ofs == OFS_POINTER) begin
                    nxt_rdata = pointer_ff;
                end else if (ofs == OFS_PCLATCH) begin
                    nxt_rdata = pclatch_ff;
                end else if (ofs == OFS_INTCTL) begin
                    nxt_rdata = intctl_ff;
                end else if (i_periph_hit) begin
                    nxt_rdata = i_periph_rdata;
                end else begin
                    unimpl = 1'b1;
                end
            end
            BDMM_HIT_NONE: unimpl = 1'b1;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= ZERO_BYTE;
        end else if (i_core_req.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // core registers: plain flops, no refresh needed when the clock halts
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_ff <= FLAGS_RESET;
            pointer_ff <= POINTER_RESET;
            pclatch_ff <= PCLATCH_RESET;
            intctl_ff <= INTCTL_RESET;
        end else if (core_wr && hit == BDMM_HIT_SFR) begin
            if (ofs == OFS_FLAGS) begin
                flags_ff <= i_core_req.wdata;
            end
            if (ofs == OFS_POINTER) begin
                pointer_ff <= i_core_req.wdata;
            end
            if (ofs == OFS_PCLATCH) begin
                pclatch_ff <= i_core_req.wdata;
            end
            if (ofs == OFS_INTCTL) begin
                intctl_ff <= i_core_req.wdata;
            end
        end
    end

    // gpr ram; no reset, contents undefined until written
    generate
        for (genvar b = 0; b < 2; b++) begin : g_bank
            always_ff @(posedge i_clk) begin
                if (core_wr && hit == BDMM_HIT_GPR && bank == 1'(b)) begin
                    gpr_ff[b][gpr_idx] <= i_core_req.wdata;
                end
            end
        end
    endgenerate

    // peripheral access strobes for every sfr offset except the core registers and the indirect slot
    assign o_periph_req.addr = eff_addr;
    assign o_periph_req.wdata = i_core_req.wdata;
    assign o_periph_req.wr = core_wr && hit == BDMM_HIT_SFR && !sfr_core && !sfr_is_ind;
    assign o_periph_req.rd = i_core_req.rd && hit == BDMM_HIT_SFR && !sfr_core && !sfr_is_ind;
    assign o_pcl_wr = core_wr && hit == BDMM_HIT_SFR && ofs == OFS_PCL;

    assign o_rdata = rdata_ff;
    assign o_eff_addr = eff_addr;
    assign o_hit_unimpl = unimpl;
    assign o_core_regs.flags = flags_ff;
    assign o_core_regs.pointer = pointer_ff;
    assign o_core_regs.pclatch = pclatch_ff;
    assign o_core_regs.intctl = intctl_ff;

    // calibration fetch guard: code must never run from the constant region
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fetch_fault_ff <= 1'b0;
        end else if (i_fetch_valid && i_fetch_addr >= CAL_BASE) begin
            fetch_fault_ff <= 1'b1;
        end else if (ack_ff && avs_write && avs_address == AV_FETCH_ERR && avs_byteenable[0]
            && avs_writedata[0]) begin
            fetch_fault_ff <= 1'b0;
        end
    end
    assign o_fetch_fault = fetch_fault_ff;

    // avalon slave: one wait cycle, answer on the second edge
    logic av_req;
    logic av_take;
    assign av_req = avs_read || avs_write;
    assign av_take = av_req && ack_ff;
    assign avs_waitrequest = av_req && !ack_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= av_req && !ack_ff;
        end
    end

    // four bytes per constant, exponent first, then mantissa high/mid/low
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cal_idx_ff <= '0;
            cal_lock_ff <= 1'b0;
        end else if (av_take && avs_write) begin
            if (avs_address == AV_CTRL && avs_byteenable[0]) begin
                cal_lock_ff <= cal_lock_ff | avs_writedata[0];
            end
            if (avs_address == AV_CAL_ADDR && avs_byteenable[0]) begin
                cal_idx_ff <= avs_writedata[CAL_IDX_W-1:0];
            end
            if (avs_address == AV_CAL_DATA) begin
                cal_idx_ff <= CAL_IDX_W'(cal_idx_ff + 1'b1);
            end
        end else if (av_take && avs_read && avs_address == AV_CAL_DATA) begin
            cal_idx_ff <= CAL_IDX_W'(cal_idx_ff + 1'b1);
        end
    end

    // constants written once at the factory, then frozen by the lock
    always_ff @(posedge i_clk) begin
        if (av_take && avs_write && avs_address == AV_CAL_DATA && avs_byteenable[0] && !cal_lock_ff) begin
            cal_ff[cal_idx_ff] <= avs_writedata[7:0];
        end
    end

    always_comb begin
        unique case (avs_address)
            AV_CTRL: avs_rdata_mux = {31'h0000_0000, cal_lock_ff};
            AV_STATUS: avs_rdata_mux = {16'h0000, pointer_ff, flags_ff};
            AV_CAL_ADDR: avs_rdata_mux = {{(32-CAL_IDX_W){1'b0}}, cal_idx_ff};
            AV_CAL_DATA: avs_rdata_mux = {24'h00_0000, cal_ff[cal_idx_ff]};
            AV_FETCH_ERR: avs_rdata_mux = {31'h0000_0000, fetch_fault_ff};
            default: avs_rdata_mux = AV_UNMAPPED;
        endcase
    end
    assign avs_readdata = av_take ? avs_rdata_mux : AV_UNMAPPED;
endmodule // bdmm_memory_map

`default_nettype wire

// >>> bdmm_memory_map_chk.sv
// bdmm_memory_map_chk: decode checks on the core side of the decoder
// assumes the top module's ports only; attached by bind below
`timescale 1ns/1ns
`default_nettype none
module bdmm_memory_map_chk
    import bdmm_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // core side
    input wire bdmm_core_req_t i_core_req,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] o_eff_addr,
    input wire logic o_hit_unimpl,
    input wire bdmm_core_regs_t o_core_regs,
    input wire logic o_pcl_wr,
    // fetch guard
    input wire logic [11:0] i_fetch_addr,
    input wire logic i_fetch_valid,
    input wire logic o_fetch_fault
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic dir;
    logic [6:0] ofs;
    assign ofs = i_core_req.dir_ofs;
    assign dir = !i_core_req.indirect && ofs != OFS_INDIRECT;
    bank_low_a: assert property (dir && !o_core_regs.flags[FLAGS_BANK_BIT] |-> o_eff_addr == {1'b0, ofs})
        else $error("bank 0 address wrong");
    bank_high_a: assert property (dir && o_core_regs.flags[FLAGS_BANK_BIT] |-> o_eff_addr == (BANK1_BASE | ofs))
        else $error("bank 1 address wrong");
    indirect_addr_a: assert property (!dir |-> o_eff_addr == o_core_regs.pointer)
        else $error("indirect address wrong");
    unimpl_zero_a: assert property (i_core_req.rd && o_hit_unimpl |=> o_rdata == ZERO_BYTE)
        else $error("unimplemented read not zero");
    unimpl_write_a: assert property (i_core_req.wr && o_hit_unimpl |=> $stable(o_core_regs))
        else $error("unimplemented write changed a core register");
    flags_read_a: assert property (i_core_req.rd && !i_core_req.wr && dir && ofs == OFS_FLAGS
        |=> o_rdata == $past(o_core_regs.flags))
        else $error("flags read wrong");
    pcl_mirror_a: assert property (i_core_req.wr && dir && ofs == OFS_PCL |-> o_pcl_wr)
        else $error("pc low write missed");
    ptr_self_a: assert property (i_core_req.rd && !dir && o_core_regs.pointer[6:0] == OFS_INDIRECT
        |=> o_rdata == ZERO_BYTE)
        else $error("indirect location not empty");
    fetch_cal_a: assert property (i_fetch_valid && i_fetch_addr >= CAL_BASE |=> o_fetch_fault)
        else $error("calibration fetch not flagged");
endmodule // bdmm_memory_map_chk
bind bdmm_memory_map bdmm_memory_map_chk chk (.i_clk, .i_rst, .i_core_req, .o_rdata, .o_eff_addr,
    .o_hit_unimpl, .o_core_regs, .o_pcl_wr, .i_fetch_addr, .i_fetch_valid, .o_fetch_fault);
`default_nettype wire

// >>> bdmm_pkg.sv
// bdmm_pkg: constants and carrier types for the banked data memory decoder
// assumes an 8-bit core and an Avalon-MM control path with 32-bit data
package bdmm_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DADDR_W = 8;
    localparam int unsigned BANK_ADDR_W = 7;
    localparam int unsigned BANK_SIZE = 128;
    localparam int unsigned GPR_PER_BANK = 96;
    localparam int unsigned CAL_WORDS = 64;
    localparam logic [7:0] BANK1_BASE = 8'h80;
    localparam logic [6:0] OFS_LAST = 7'h7f;
    localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
    localparam logic [6:0] OFS_INDIRECT = 7'h00;
    localparam logic [6:0] OFS_PCL = 7'h02;
    localparam logic [6:0] OFS_FLAGS = 7'h03;
    localparam logic [6:0] OFS_POINTER = 7'h04;
    localparam logic [6:0] OFS_PCLATCH = 7'h0a;
    localparam logic [6:0] OFS_INTCTL = 7'h0b;
    localparam int unsigned FLAGS_BANK_BIT = 5;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h18;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] PCLATCH_RESET = 8'h00;
    localparam logic [7:0] INTCTL_RESET = 8'h00;
    // calibration region in program memory
    localparam logic [11:0] CAL_BASE = 12'hfc0;
    localparam logic [11:0] CAL_LAST = 12'hfff;
    localparam int unsigned CAL_BYTES_PER_CONST = 4;
    // avalon register offsets (byte addresses)
    localparam logic [7:0] AV_CTRL = 8'h00;
    localparam logic [7:0] AV_STATUS = 8'h04;
    localparam logic [7:0] AV_CAL_ADDR = 8'h08;
    localparam logic [7:0] AV_CAL_DATA = 8'h0c;
    localparam logic [7:0] AV_FETCH_ERR = 8'h10;
    localparam logic [31:0] AV_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        BDMM_HIT_NONE,
        BDMM_HIT_SFR,
        BDMM_HIT_GPR
    } bdmm_hit_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic indirect;
        logic [6:0] dir_ofs;
        logic [7:0] wdata;
    } bdmm_core_req_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] pointer;
        logic [7:0] pclatch;
        logic [7:0] intctl;
    } bdmm_core_regs_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bdmm_periph_req_t;
endpackage

// >>> tb_top.sv
// tb_top: self-checking bench for the banked data memory decoder
// assumes bdmm_core_model stands in for the core side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bdmm_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_fetch_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic o_hit_unimpl, o_pcl_wr, i_periph_hit, o_fetch_fault, avs_waitrequest;
    logic [7:0] o_rdata, o_eff_addr, i_pc_low, i_periph_rdata, avs_address = 8'h00;
    logic [11:0] i_fetch_addr = 12'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [3:0] avs_byteenable = 4'hf;
    bdmm_core_req_t i_core_req = '0;
    bdmm_core_regs_t o_core_regs;
    bdmm_periph_req_t o_periph_req;
    int failures = 0, check_count = 0, cyc = 0;
    always #25 i_clk = ~i_clk;
    bdmm_memory_map dut (.i_clk, .i_rst, .i_core_req, .o_rdata, .o_eff_addr, .o_hit_unimpl,
        .o_core_regs, .i_pc_low, .o_pcl_wr, .o_periph_req, .i_periph_rdata, .i_periph_hit,
        .i_fetch_addr, .i_fetch_valid, .o_fetch_fault, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    bdmm_core_model partner (.i_clk, .i_pcl_wr(o_pcl_wr), .i_wdata(i_core_req.wdata),
        .i_preq(o_periph_req), .o_pc_low(i_pc_low), .o_prdata(i_periph_rdata), .o_phit(i_periph_hit));
    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    // one core access, then one idle cycle
    task automatic core(input logic r, w, ind, input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_core_req <= {r, w, ind, a, d};
        @(posedge i_clk);
        i_core_req <= '0;
        #1;
    endtask
    task automatic cw(input logic [6:0] a, input logic [7:0] d);
        core(1'b0, 1'b1, 1'b0, a, d);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        core(1'b1, 1'b0, 1'b0, a, 8'h00);
        check("core read", o_rdata, e);
    endtask
    // held until the rising edge that sees waitrequest low; only the bench timeout ends a hang
    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do begin
            @(posedge i_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            summarize;
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        av(1'b0, 8'h20, 32'h0);
        check("unmapped", q, AV_UNMAPPED);
        av(1'b0, AV_STATUS, 32'h0);
        check("status", q[15:0], {POINTER_RESET, FLAGS_RESET});
        $display("test reset done");
        cw(7'h20, 8'ha5);
        cw(OFS_FLAGS, 8'h38);
        cw(7'h20, 8'h5a);
        cw(OFS_LAST, 8'hc3);
        cw(OFS_POINTER, 8'hff);
        cw(OFS_PCL, 8'h77);
        rdc(7'h20, 8'h5a);
        rdc(OFS_LAST, 8'hc3);
        rdc(OFS_FLAGS, 8'h38);
        cw(7'h05, 8'h6c);
        rdc(7'h05, 8'h00);
        cw(OFS_FLAGS, 8'h18);
        rdc(7'h20, 8'ha5);
        rdc(OFS_POINTER, 8'hff);
        rdc(OFS_PCL, 8'h77);
        rdc(OFS_INDIRECT, 8'hc3);
        cw(7'h05, 8'h6c);
        rdc(7'h05, 8'h6c);
        cw(7'h09, 8'hff);
        rdc(7'h09, 8'h00);
        cw(OFS_POINTER, 8'ha0);
        core(1'b0, 1'b1, 1'b1, 7'h55, 8'h33);
        core(1'b1, 1'b0, 1'b1, 7'h11, 8'h00);
        check("indirect", o_rdata, 8'h33);
        cw(OFS_FLAGS, 8'h38);
        rdc(7'h20, 8'h33);
        cw(OFS_POINTER, 8'h80);
        cw(OFS_INDIRECT, 8'h99);
        rdc(OFS_INDIRECT, 8'h00);
        cw(OFS_PCLATCH, 8'h1e);
        cw(OFS_INTCTL, 8'hc4);
        cw(OFS_FLAGS, 8'h18);
        rdc(OFS_PCLATCH, 8'h1e);
        rdc(OFS_INTCTL, 8'hc4);
        check("core regs", {o_core_regs.pclatch, o_core_regs.intctl}, 32'h0000_1ec4);
        $display("test banks done");
        for (int b = 0; b < 61; b += 60) begin
            av(1'b1, AV_CAL_ADDR, b);
            for (int i = 0; i < 4; i++) av(1'b1, AV_CAL_DATA, 32'h80 + b + i);
        end
        for (int b = 0; b < 61; b += 60) begin
            av(1'b1, AV_CAL_ADDR, b);
            for (int i = 0; i < 4; i++) begin
                av(1'b0, AV_CAL_DATA, 32'h0);
                check("cal byte", q[7:0], 8'h80 + b + i);
            end
        end
        av(1'b1, AV_CTRL, 32'h1);
        av(1'b0, AV_CTRL, 32'h0);
        check("cal lock", q[0], 1'b1);
        av(1'b1, AV_CAL_ADDR, 32'h0);
        av(1'b1, AV_CAL_DATA, 32'h55);
        av(1'b1, AV_CAL_ADDR, 32'h0);
        av(1'b0, AV_CAL_DATA, 32'h0);
        check("locked byte", q[7:0], 8'h80);
        $display("test calibration done");
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_fetch_addr <= k ? CAL_BASE : CAL_BASE - 12'h001;
            i_fetch_valid <= 1'b1;
            @(posedge i_clk);
            i_fetch_valid <= 1'b0;
            av(1'b0, AV_FETCH_ERR, 32'h0);
            check("fetch fault", q[0], k);
        end
        av(1'b1, AV_FETCH_ERR, 32'h1);
        av(1'b0, AV_FETCH_ERR, 32'h0);
        check("fault clear", q[0], 1'b0);
        $display("test fetch done");
        summarize;
    end
endmodule // tb_top
`default_nettype wire
